// file: dv/pif_top_asserts.sv
// Purpose: port checks for pif_top
// Assumes: zero wait apb, read data and error registered in setup cycle
// Notes: flag bits are judged by the bench, not here
`timescale 1ns/1ps
module pif_top_asserts
   import pif_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irqTake
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // completing access, the slave never waits
   wire acc = psel && penable;
   wire setup = psel && !penable;
   wire rd = setup && !pwrite;
   wire mapped = paddr inside {PIF_OFS_CTRL0, PIF_OFS_CTRL1, PIF_OFS_EDGE, PIF_OFS_STAT};
   wire bad = setup && (!mapped || (pwrite && paddr == PIF_OFS_STAT));
   a_ready_up: assert property ($past(reset_n) |-> pready)
      else $error("pready low after reset");
   a_err_flag: assert property (bad |=> pslverr)
      else $error("bad access not flagged");
   a_err_cause: assert property (pslverr |-> $past(bad))
      else $error("error without cause");
   a_rd_ctrl0: assert property (rd && paddr == PIF_OFS_CTRL0 |=> prdata[31:7] == 0)
      else $error("ctrl0 spare bits set");
   a_rd_ctrl1: assert property (rd && paddr == PIF_OFS_CTRL1 |=> !prdata[4] && !prdata[0])
      else $error("ctrl1 spare bits set");
   a_rd_edge: assert property (rd && paddr == PIF_OFS_EDGE |=> prdata[31:2] == 0)
      else $error("edge select too wide");
   a_rd_hold: assert property (!rd |=> $stable(prdata))
      else $error("read data moved");
   a_irq_gate: assert property (acc && pwrite && paddr == PIF_OFS_CTRL0 && !pwdata[0]
      |-> ##2 !irqTake)
      else $error("interrupt taken while disabled");
   c_write: cover property (acc && pwrite);
   c_irq: cover property ($rose(irqTake));
   c_err: cover property (pslverr);
endmodule
bind pif_top pif_top_asserts chk (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .irqTake);

// file: dv/pif_top_tb.sv
// Purpose: self-checking bench for pif_top
// Assumes: zero wait apb, read data taken at the completing edge
// Notes: random register data from a fixed seed
`timescale 1ns/1ps
module pif_top_tb
   import pif_pkg::*;
;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, extPin = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, irqTake;
   logic [4:0] ev = 5'h00; // one-cycle event pulses
   int nMismatch = 0, compares = 0;
   logic [7:0] evAddr [5] = '{PIF_OFS_CTRL0, PIF_OFS_CTRL0, PIF_OFS_CTRL1, PIF_OFS_CTRL1,
      PIF_OFS_CTRL1};
   int evBit [5] = '{PIF_B0_G0F, PIF_B0_CMPF, PIF_B1_TBF, PIF_B1_ADF, PIF_B1_G2F};
   pif_top uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .extPin, .group0Event(ev[0]), .comparatorEvent(ev[1]), .timebase0Event(ev[2]),
      .conversionEvent(ev[3]), .group2Event(ev[4]), .irqTake);
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] expReg(input logic [7:0] a, input logic [31:0] d);
      return {24'h00_0000, d[7:0] & (a == PIF_OFS_CTRL0 ? PIF_CTRL0_MASK : PIF_CTRL1_MASK)};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         nMismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one apb transfer; sample and release at the completing edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic irqStep(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      @(posedge clk);
      #1 chk(irqTake, e);
   endtask
   task automatic printVerdict;
      if (nMismatch == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      nMismatch++;
      printVerdict;
   end
   initial begin
      logic [7:0] a;
      logic [31:0] d;
      void'($urandom(95314));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, PIF_OFS_CTRL0, 32'h0000_0000);
      chk(rd, PIF_CTRL0_RST);
      apb(1'b0, PIF_OFS_CTRL1, 32'h0000_0000);
      chk(rd, PIF_CTRL1_RST);
      apb(1'b0, PIF_OFS_EDGE, 32'h0000_0000);
      chk(rd, PIF_EDGE_RST);
      for (int i = 0; i < 16; i++) begin
         a = i[0] ? PIF_OFS_CTRL1 : PIF_OFS_CTRL0;
         d = $urandom;
         apb(1'b1, a, d);
         apb(1'b0, a, 32'h0000_0000);
         chk(rd, expReg(a, d));
      end
      // each peripheral pulse must land in its own flag only
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, evAddr[i], 32'h0000_0000);
         @(posedge clk);
         ev[i] <= 1'b1;
         @(posedge clk);
         ev[i] <= 1'b0;
         apb(1'b0, evAddr[i], 32'h0000_0000);
         chk(rd, 32'h0000_0001 << evBit[i]);
      end
      irqStep(PIF_OFS_CTRL1, 32'h0000_0022, 1'b1 & 1'b0);
      irqStep(PIF_OFS_CTRL0, 32'h0000_0000, 1'b0);
      irqStep(PIF_OFS_CTRL0, 32'h0000_0001, 1'b1);
      irqStep(PIF_OFS_CTRL1, 32'h0000_0020, 1'b0);
      // rising then falling pin edge under every selection code
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, PIF_OFS_EDGE, 32'(s));
         for (int k = 0; k < 2; k++) begin
            apb(1'b1, PIF_OFS_CTRL0, 32'h0000_0000);
            @(posedge clk);
            extPin <= ~extPin;
            repeat (3) @(posedge clk);
            apb(1'b0, PIF_OFS_CTRL0, 32'h0000_0000);
            chk(rd[PIF_B0_EXTF], k ? s[1] : s[0]);
         end
      end
      apb(1'b1, PIF_OFS_STAT, 32'h0000_00FF);
      chk(err, 1'b1);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk(err, 1'b1);
      apb(1'b1, PIF_OFS_CTRL1, 32'h0000_0022);
      apb(1'b0, PIF_OFS_STAT, 32'h0000_0000);
      chk(err, 1'b0);
      chk(rd, 32'h0000_0001);
      printVerdict;
   end
endmodule

// file: logic/pif_edge_det.sv
// Purpose: edge detector for the external interrupt pin
// Assumes: pin already synchronous to clk
// Notes: first cycle after reset sees no edge
`timescale 1ns/1ps
module pif_edge_det
   import pif_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   pif_edge_if.det e
);
   logic prev_reg; // pin level one cycle ago
   logic valid_reg; // prev_reg holds a real sample
   wire rise = e.pinLevel & ~prev_reg & valid_reg;
   wire fall = ~e.pinLevel & prev_reg & valid_reg;
   // select the edges asked for
   assign e.hit = (e.edgeSel == PIF_EDGE_RISE) ? rise :
                  (e.edgeSel == PIF_EDGE_FALL) ? fall :
                  (e.edgeSel == PIF_EDGE_BOTH) ? (rise | fall) : 1'b0;
   // ------------------------------------------------------------
   // history
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_reg <= 1'b0;
         valid_reg <= 1'b0;
      end else begin
         prev_reg <= e.pinLevel;
         valid_reg <= 1'b1;
      end
   end
endmodule

// file: logic/pif_edge_if.sv
// Purpose: carries pin edge detect signals between modules
// Assumes: single clock
// Notes: detector drives hit, top drives pin and select
`timescale 1ns/1ps
interface pif_edge_if;
   logic pinLevel; // synchronous pin level
   logic [1:0] edgeSel; // edge selection code
   logic hit; // one-cycle detected edge
   modport det (input pinLevel, input edgeSel, output hit);
   modport top (output pinLevel, output edgeSel, input hit);
endinterface

// file: logic/pif_pkg.sv
// Purpose: constants for the primary interrupt flag block
// Assumes: 32-bit apb, one aligned word per register
// Notes: 8-bit registers sit in the low byte, upper bits read zero
package pif_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] PIF_OFS_CTRL0 = 8'h00; // primary_irq_ctrl0
   localparam logic [7:0] PIF_OFS_CTRL1 = 8'h04; // primary_irq_ctrl1
   localparam logic [7:0] PIF_OFS_EDGE = 8'h08; // edge select
   localparam logic [7:0] PIF_OFS_STAT = 8'h0C; // pending status, read only
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] PIF_CTRL0_RST = 8'h00;
   localparam logic [7:0] PIF_CTRL1_RST = 8'h00;
   localparam logic [1:0] PIF_EDGE_RST = 2'h3; // both edges
   // writable bit masks (unimplemented bits read zero)
   localparam logic [7:0] PIF_CTRL0_MASK = 8'h7F;
   localparam logic [7:0] PIF_CTRL1_MASK = 8'hEE;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int PIF_B0_GLOBAL = 0;
   localparam int PIF_B0_EXTEN = 1;
   localparam int PIF_B0_CMPEN = 2;
   localparam int PIF_B0_G0EN = 3;
   localparam int PIF_B0_EXTF = 4;
   localparam int PIF_B0_CMPF = 5;
   localparam int PIF_B0_G0F = 6;
   localparam int PIF_B1_G2EN = 1;
   localparam int PIF_B1_ADEN = 2;
   localparam int PIF_B1_TBEN = 3;
   localparam int PIF_B1_G2F = 5;
   localparam int PIF_B1_ADF = 6;
   localparam int PIF_B1_TBF = 7;
   // edge selection codes
   localparam logic [1:0] PIF_EDGE_OFF = 2'h0;
   localparam logic [1:0] PIF_EDGE_RISE = 2'h1;
   localparam logic [1:0] PIF_EDGE_FALL = 2'h2;
   localparam logic [1:0] PIF_EDGE_BOTH = 2'h3;
   localparam int PIF_NSRC = 6; // sources with flag and enable
endpackage

// file: logic/pif_top.sv
// Purpose: primary interrupt control registers with apb access
// Assumes: apb slave, zero wait states; event inputs are one-cycle pulses
// Notes: hardware set wins over a software clear in the same cycle
//
// Overview of operation
// - bit6 ctrl0 shows group0 pending, writable
// - bit5 ctrl0 holds comparator request flag
// - bit1 ctrl0 enables external pin interrupt
// - bit7 ctrl1 holds time base request flag
// - bit6 ctrl1 holds conversion request flag
// - bit5 ctrl1 holds group2 request flag
// - bit1 ctrl1 enables group2 interrupts
// - pin flag set per two-bit edge select
`timescale 1ns/1ps
module pif_top
   import pif_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extPin,
   input wire logic group0Event,
   input wire logic comparatorEvent,
   input wire logic timebase0Event,
   input wire logic conversionEvent,
   input wire logic group2Event,
   output logic irqTake
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] ctrl0_reg; // primary_irq_ctrl0
   logic [7:0] ctrl1_reg; // primary_irq_ctrl1
   logic [1:0] edge_reg; // edge_select_hi, edge_select_lo
   logic [7:0] ctrl0_next;
   logic [7:0] ctrl1_next;
   logic [31:0] prdata_next;
   logic irqTake_next;
   pif_edge_if eif ();
   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   wire access = psel & penable; // single-cycle access phase, pready registered high from the first clock after reset
   // read data and error are registered in the setup cycle so they stand
   // at the completing edge; a flag set during the access reads next time
   wire setup = psel & ~penable;
   wire wrEn = access & pwrite;
   wire hitCtrl0 = (paddr == PIF_OFS_CTRL0);
   wire hitCtrl1 = (paddr == PIF_OFS_CTRL1);
   wire hitEdge = (paddr == PIF_OFS_EDGE);
   wire hitStat = (paddr == PIF_OFS_STAT);
   wire mapped = hitCtrl0 | hitCtrl1 | hitEdge | hitStat;
   wire wrCtrl0 = wrEn & hitCtrl0;
   wire wrCtrl1 = wrEn & hitCtrl1;
   // status writes are refused; unmapped addresses give an error
   wire errNext = setup & (~mapped | (pwrite & hitStat));
   // ------------------------------------------------------------
   // pin edge detection
   // ------------------------------------------------------------
   assign eif.pinLevel = extPin;
   assign eif.edgeSel = edge_reg;
   pif_edge_det u_edge (
      .clk(clk),
      .reset_n(reset_n),
      .e(eif.det)
   );
   // hardware set vectors placed at flag positions
   wire [7:0] set0 = ({7'h00, group0Event} << PIF_B0_G0F)
      | ({7'h00, comparatorEvent} << PIF_B0_CMPF)
      | ({7'h00, eif.hit} << PIF_B0_EXTF);
   wire [7:0] set1 = ({7'h00, timebase0Event} << PIF_B1_TBF)
      | ({7'h00, conversionEvent} << PIF_B1_ADF)
      | ({7'h00, group2Event} << PIF_B1_G2F);
   // software write then hardware set on top, so set beats clear
   assign ctrl0_next = ((wrCtrl0 ? pwdata[7:0] : ctrl0_reg) | set0) & PIF_CTRL0_MASK;
   assign ctrl1_next = ((wrCtrl1 ? pwdata[7:0] : ctrl1_reg) | set1) & PIF_CTRL1_MASK;
   // ------------------------------------------------------------
   // interrupt qualification
   // ------------------------------------------------------------
   wire [PIF_NSRC-1:0] flags = {ctrl0_reg[PIF_B0_G0F], ctrl0_reg[PIF_B0_CMPF],
      ctrl0_reg[PIF_B0_EXTF], ctrl1_reg[PIF_B1_TBF], ctrl1_reg[PIF_B1_ADF],
      ctrl1_reg[PIF_B1_G2F]};
   wire [PIF_NSRC-1:0] enables = {ctrl0_reg[PIF_B0_G0EN], ctrl0_reg[PIF_B0_CMPEN],
      ctrl0_reg[PIF_B0_EXTEN], ctrl1_reg[PIF_B1_TBEN], ctrl1_reg[PIF_B1_ADEN],
      ctrl1_reg[PIF_B1_G2EN]};
   wire [PIF_NSRC-1:0] pend = flags & enables;
   assign irqTake_next = ctrl0_reg[PIF_B0_GLOBAL] & (|pend);
   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   wire [7:0] rd8 = hitCtrl0 ? ctrl0_reg :
                    hitCtrl1 ? ctrl1_reg :
                    hitEdge ? {6'h00, edge_reg} :
                    hitStat ? {2'h0, pend} : 8'h00;
   assign prdata_next = (setup & ~pwrite) ? {24'h0000_00, rd8} : prdata;
   // ------------------------------------------------------------
   // state update
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl0_reg <= PIF_CTRL0_RST;
         ctrl1_reg <= PIF_CTRL1_RST;
         edge_reg <= PIF_EDGE_RST;
      end else begin
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
         if (wrEn & hitEdge) begin
            edge_reg <= pwdata[1:0];
         end
      end
   end
   // bus answer and interrupt output registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         irqTake <= 1'b0;
      end else begin
         prdata <= prdata_next;
         pslverr <= errNext;
         irqTake <= irqTake_next;
      end
   end
   // zero wait states: low in reset, ready from the first clock after reset onward
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
      end
   end
endmodule
